// ---- include/etf_params.svh ----
`ifndef ETF_PARAMS_SVH
`define ETF_PARAMS_SVH

// board lanes and per-board buffer geometry
`define ETF_NBOARD      8
`define ETF_BRD_W       3
`define ETF_BUF_AW      12
`define ETF_BUF_DEPTH   4096
`define ETF_BUF_LAST    12'hfff
`define ETF_WORD_W      32

// train shape
`define ETF_NCHAN       16
`define ETF_MAX_SAMPLES 254
`define ETF_MAX_TRAIN   (3 + `ETF_NCHAN * (`ETF_MAX_SAMPLES + 1))
`define ETF_ADDR_SW2    12'h001
`define ETF_ADDR_RAW0   12'h002
`define ETF_IDX_ONE     12'h001

// word fields
`define ETF_BIT_VALID   31
`define ETF_KEEP_HI     31
`define ETF_KEEP_LO     25
`define ETF_BRD_HI      24
`define ETF_BRD_LO      22
`define ETF_LOW_HI      21
`define ETF_FMT_HI      21
`define ETF_FMT_LO      18
`define ETF_CH_HI       21
`define ETF_CH_LO       17
`define ETF_BIT_HIT_TOP 17
`define ETF_BIT_START   16
`define ETF_BIT_END     15
`define ETF_HITS_HI     14
`define ETF_LEN_HI      14
`define ETF_LEN_PAD     3'h0

// register map, byte addresses
`define ETF_AXI_AW      8
`define ETF_REG_CTRL    8'h00
`define ETF_REG_STATUS  8'h04
`define ETF_REG_DROPS   8'h08
`define ETF_REG_ERRS    8'h0c
`define ETF_REG_FWD     8'h10
`define ETF_REG_HITS    8'h14
`define ETF_REG_FMT     8'h18
`define ETF_CTRL_EN     0
`define ETF_CTRL_FLUSH  1
`define ETF_CTRL_EN_RST 1'h1
`define ETF_RESP_OKAY   2'h0
`define ETF_RESP_SLVERR 2'h2
`define ETF_ZERO32      32'h0000_0000

`endif

// ---- include/etf_pkg.sv ----
`include "etf_params.svh"

package etf_pkg;

	typedef struct packed {
		logic                     valid;
		logic [`ETF_WORD_W-1:0]   data;
	} etf_word_t;

	typedef enum logic [1:0] {
		FWD_SEL  = 2'h0,
		FWD_ADDR = 2'h1,
		FWD_LOAD = 2'h3,
		FWD_SEND = 2'h2
	} etf_fwd_st_t;

	typedef enum logic [1:0] {
		BUF_EMPTY = 2'h0,
		BUF_FILL  = 2'h1,
		BUF_FULL  = 2'h3
	} etf_buf_st_t;

endpackage : etf_pkg

// ---- hdl/etf_train_buf.sv ----
`timescale 1ns/1ps
`include "etf_params.svh"

module etf_train_buf #(
	parameter logic [`ETF_BRD_W-1:0] BOARD = 3'h0
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     flush,
	input  wire etf_pkg::etf_word_t       in_word,
	input  wire logic [`ETF_BUF_AW-1:0]   rd_addr,
	output logic [`ETF_WORD_W-1:0]        rd_data,
	output logic                          full,
	output logic [`ETF_BUF_AW-1:0]        len,
	input  wire logic                     release_buf,
	output logic                          dropped,
	output logic                          bad
);
	logic [`ETF_WORD_W-1:0] mem [0:`ETF_BUF_DEPTH-1];
	etf_pkg::etf_buf_st_t   st_r;
	etf_pkg::etf_buf_st_t   st_nxt;
	logic [`ETF_BUF_AW-1:0] wa_r;
	logic [4:0]             last_ch_r;

	wire w_ok     = in_word.valid & in_word.data[`ETF_BIT_VALID];
	wire is_start = in_word.data[`ETF_BIT_START];
	wire is_end   = in_word.data[`ETF_BIT_END];
	wire empty    = st_r == etf_pkg::BUF_EMPTY;
	wire filling  = st_r == etf_pkg::BUF_FILL;
	// the only acceptance point is the first starting word
	wire wr_en    = w_ok & ((empty & is_start) | (filling & ~is_start));
	wire [`ETF_BUF_AW-1:0] wa = empty ? '0 : wa_r;
	wire [`ETF_BUF_AW-1:0] wa_inc = wa + `ETF_IDX_ONE;
	// bits above are passed through untouched
	wire [`ETF_WORD_W-1:0] wdata = {in_word.data[`ETF_KEEP_HI:`ETF_KEEP_LO],
		BOARD, in_word.data[`ETF_LOW_HI:0]};
	wire [4:0] chan = in_word.data[`ETF_CH_HI:`ETF_CH_LO];
	wire raw_wr  = wr_en & filling & ~is_end & (wa_r >= `ETF_ADDR_RAW0);
	// channels must never step backwards
	wire order_bad = raw_wr & (wa_r > `ETF_ADDR_RAW0) & (chan < last_ch_r);
	// a train whose 4096th word is not its closing word is aborted
	wire over    = wr_en & filling & ~is_end & (wa_r == `ETF_BUF_LAST);
	// closing length counts both starts and the closing word
	wire len_bad = wr_en & filling & is_end &
		(in_word.data[`ETF_LEN_HI:0] != {`ETF_LEN_PAD, wa_inc});

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			etf_pkg::BUF_EMPTY: if (wr_en) st_nxt = etf_pkg::BUF_FILL;
			etf_pkg::BUF_FILL: begin
				if (over)
					st_nxt = etf_pkg::BUF_EMPTY;
				else if (wr_en & is_end)
					st_nxt = etf_pkg::BUF_FULL;
			end
			etf_pkg::BUF_FULL: if (release_buf) st_nxt = etf_pkg::BUF_EMPTY;
			default: st_nxt = etf_pkg::BUF_EMPTY;
		endcase
		// software flush outranks a train closing in the same cycle
		if (flush)
			st_nxt = etf_pkg::BUF_EMPTY;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r      <= etf_pkg::BUF_EMPTY;
			wa_r      <= '0;
			len       <= '0;
			last_ch_r <= 5'h00;
			dropped   <= 1'b0;
			bad       <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			dropped <= w_ok & is_start & ~empty;
			bad     <= (in_word.valid & ~in_word.data[`ETF_BIT_VALID]) |
				len_bad | order_bad | over;
			if (wr_en)
				wa_r <= wa_inc;
			if (wr_en & is_end)
				len <= wa_inc;
			if (raw_wr)
				last_ch_r <= chan;
		end
	end

	// storage has no reset; it is only read below a valid length
	always_ff @(posedge clk) begin
		if (wr_en)
			mem[wa] <= wdata;
		rd_data <= mem[rd_addr];
	end

	assign full = st_r == etf_pkg::BUF_FULL;

	property p_occupied_drop;
		@(posedge clk) disable iff (rst)
		(st_r == etf_pkg::BUF_FULL) |-> !wr_en;
	endproperty
	a_occupied_drop: assert property (p_occupied_drop)
		else $error("word stored into an occupied buffer");

	property p_accept_at_start;
		@(posedge clk) disable iff (rst)
		(empty && wr_en && !flush) |-> is_start ##1
			(st_r == etf_pkg::BUF_FILL);
	endproperty
	a_accept_at_start: assert property (p_accept_at_start)
		else $error("train accepted at a word other than its first");

	property p_board_insert;
		@(posedge clk) disable iff (rst)
		wr_en |-> (wdata[`ETF_BRD_HI:`ETF_BRD_LO] == BOARD);
	endproperty
	a_board_insert: assert property (p_board_insert)
		else $error("board address not inserted");

	property p_valid_only;
		@(posedge clk) disable iff (rst)
		(in_word.valid && !in_word.data[`ETF_BIT_VALID]) |-> !wr_en ##1 bad;
	endproperty
	a_valid_only: assert property (p_valid_only)
		else $error("word with valid flag clear was not rejected");

	property p_len_counts_all;
		@(posedge clk) disable iff (rst)
		$rose(full) |-> (len == $past(wa_r) + `ETF_IDX_ONE);
	endproperty
	a_len_counts_all: assert property (p_len_counts_all)
		else $error("stored length does not count every word");

endmodule : etf_train_buf

// ---- hdl/etf_framer.sv ----
`timescale 1ns/1ps
`include "etf_params.svh"

module etf_framer (
	input  wire logic                         CLK,
	input  wire logic                         RST,
	input  wire etf_pkg::etf_word_t [`ETF_NBOARD-1:0] BRD_WORD,
	output logic                              HOST_VALID,
	output logic [`ETF_WORD_W-1:0]            HOST_DATA,
	output logic                              HOST_LAST,
	input  wire logic                         HOST_READY,
	input  wire logic [`ETF_AXI_AW-1:0]       S_AXI_AWADDR,
	input  wire logic                         S_AXI_AWVALID,
	output logic                              S_AXI_AWREADY,
	input  wire logic [`ETF_WORD_W-1:0]       S_AXI_WDATA,
	input  wire logic [3:0]                   S_AXI_WSTRB,
	input  wire logic                         S_AXI_WVALID,
	output logic                              S_AXI_WREADY,
	output logic [1:0]                        S_AXI_BRESP,
	output logic                              S_AXI_BVALID,
	input  wire logic                         S_AXI_BREADY,
	input  wire logic [`ETF_AXI_AW-1:0]       S_AXI_ARADDR,
	input  wire logic                         S_AXI_ARVALID,
	output logic                              S_AXI_ARREADY,
	output logic [`ETF_WORD_W-1:0]            S_AXI_RDATA,
	output logic [1:0]                        S_AXI_RRESP,
	output logic                              S_AXI_RVALID,
	input  wire logic                         S_AXI_RREADY
);
	etf_pkg::etf_fwd_st_t   st_r;
	logic [2:0]             sel_r;
	logic [`ETF_BUF_AW-1:0] idx_r;
	logic                   en_r;
	logic                   flush_r;
	logic [31:0]            drops_r;
	logic [31:0]            errs_r;
	logic [31:0]            fwd_r;
	logic [31:0]            hits_r;
	logic [3:0]             fmt_r;
	logic [`ETF_NBOARD-1:0] full_v;
	logic [`ETF_NBOARD-1:0] drop_v;
	logic [`ETF_NBOARD-1:0] bad_v;
	logic [`ETF_NBOARD-1:0] rel_v;
	logic                   sent_last;
	logic [`ETF_WORD_W-1:0] rdat_a [`ETF_NBOARD];
	logic [`ETF_BUF_AW-1:0] len_a  [`ETF_NBOARD];

	// one buffer per board lane, never shared
	genvar gi;
	generate
		for (gi = 0; gi < `ETF_NBOARD; gi++) begin : g_brd
			etf_train_buf #(
				.BOARD (3'(gi))
			) u_buf (
				.clk         (CLK),
				.rst         (RST),
				.flush       (flush_r),
				.in_word     (BRD_WORD[gi]),
				.rd_addr     (idx_r),
				.rd_data     (rdat_a[gi]),
				.full        (full_v[gi]),
				.len         (len_a[gi]),
				.release_buf (rel_v[gi]),
				.dropped     (drop_v[gi]),
				.bad         (bad_v[gi])
			);
			assign rel_v[gi] = sent_last & (sel_r == 3'(gi));
		end
	endgenerate

	// forwarding engine: round-robin poll, at most one word per three cycles
	wire [`ETF_BUF_AW-1:0] cur_len = len_a[sel_r];
	wire [`ETF_WORD_W-1:0] cur_dat = rdat_a[sel_r];
	wire go        = (st_r == etf_pkg::FWD_SEL) & en_r & full_v[sel_r];
	wire taken     = (st_r == etf_pkg::FWD_SEND) & HOST_VALID & HOST_READY;
	assign sent_last = taken & HOST_LAST;
	wire is_last   = (idx_r == cur_len - `ETF_IDX_ONE);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_r <= etf_pkg::FWD_SEL;
			sel_r <= 3'h0;
			idx_r <= '0;
		end else if (flush_r) begin
			// a flush abandons any train being forwarded
			st_r <= etf_pkg::FWD_SEL;
			idx_r <= '0;
		end else begin
			unique case (st_r)
				etf_pkg::FWD_SEL: begin
					if (go) begin
						st_r <= etf_pkg::FWD_ADDR;
						idx_r <= '0;
					end else
						sel_r <= sel_r + 3'h1;
				end
				etf_pkg::FWD_ADDR: st_r <= etf_pkg::FWD_LOAD;
				etf_pkg::FWD_LOAD: st_r <= etf_pkg::FWD_SEND;
				etf_pkg::FWD_SEND: begin
					if (sent_last) begin
						st_r <= etf_pkg::FWD_SEL;
						sel_r <= sel_r + 3'h1;
					end else if (taken) begin
						st_r <= etf_pkg::FWD_ADDR;
						idx_r <= idx_r + `ETF_IDX_ONE;
					end
				end
			endcase
		end
	end

	// host word register, words leave exactly as stored
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			HOST_VALID <= 1'b0;
			HOST_DATA  <= `ETF_ZERO32;
			HOST_LAST  <= 1'b0;
		end else if (flush_r | taken) begin
			HOST_VALID <= 1'b0;
			HOST_LAST  <= 1'b0;
		end else if (st_r == etf_pkg::FWD_LOAD) begin
			HOST_VALID <= 1'b1;
			HOST_DATA  <= cur_dat;
			HOST_LAST  <= is_last;
		end
	end

	// latch format and hit map of the last train sent
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			fmt_r  <= 4'h0;
			hits_r <= `ETF_ZERO32;
		end else if (st_r == etf_pkg::FWD_LOAD && idx_r == '0) begin
			fmt_r  <= cur_dat[`ETF_FMT_HI:`ETF_FMT_LO];
			hits_r[15:0] <= {cur_dat[`ETF_BIT_HIT_TOP],
				cur_dat[`ETF_HITS_HI:0]};
		end else if (st_r == etf_pkg::FWD_LOAD && idx_r == `ETF_ADDR_SW2) begin
			hits_r[31:16] <= {cur_dat[`ETF_BIT_HIT_TOP],
				cur_dat[`ETF_HITS_HI:0]};
		end
	end

	// AXI4-Lite write side: address and data taken in either order
	logic                   aw_hold_r;
	logic                   w_hold_r;
	logic [`ETF_AXI_AW-1:0] aw_addr_r;
	logic [31:0]            w_data_r;
	logic [3:0]             w_strb_r;
	wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
	wire w_take  = S_AXI_WVALID & S_AXI_WREADY;
	wire aw_have = aw_hold_r | aw_take;
	wire w_have  = w_hold_r | w_take;
	wire do_wr   = aw_have & w_have & ~S_AXI_BVALID;
	wire [`ETF_AXI_AW-1:0] wa_cur = aw_hold_r ? aw_addr_r : S_AXI_AWADDR;
	wire [31:0] wd_cur = w_hold_r ? w_data_r : S_AXI_WDATA;
	wire [3:0]  ws_cur = w_hold_r ? w_strb_r : S_AXI_WSTRB;
	wire wr_ctrl  = do_wr & (wa_cur == `ETF_REG_CTRL) & ws_cur[0];
	wire wr_known = (wa_cur == `ETF_REG_CTRL) | (wa_cur == `ETF_REG_STATUS) |
		(wa_cur == `ETF_REG_DROPS) | (wa_cur == `ETF_REG_ERRS) |
		(wa_cur == `ETF_REG_FWD) | (wa_cur == `ETF_REG_HITS) |
		(wa_cur == `ETF_REG_FMT);
	wire bvalid_nxt  = do_wr | (S_AXI_BVALID & ~S_AXI_BREADY);
	wire aw_hold_nxt = aw_have & ~do_wr;
	wire w_hold_nxt  = w_have & ~do_wr;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			aw_hold_r     <= 1'b0;
			w_hold_r      <= 1'b0;
			aw_addr_r     <= '0;
			w_data_r      <= `ETF_ZERO32;
			w_strb_r      <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `ETF_RESP_OKAY;
			en_r          <= `ETF_CTRL_EN_RST;
			flush_r       <= 1'b0;
		end else begin
			aw_hold_r     <= aw_hold_nxt;
			w_hold_r      <= w_hold_nxt;
			S_AXI_AWREADY <= ~aw_hold_nxt & ~bvalid_nxt;
			S_AXI_WREADY  <= ~w_hold_nxt & ~bvalid_nxt;
			S_AXI_BVALID  <= bvalid_nxt;
			if (aw_take)
				aw_addr_r <= S_AXI_AWADDR;
			if (w_take) begin
				w_data_r <= S_AXI_WDATA;
				w_strb_r <= S_AXI_WSTRB;
			end
			if (do_wr)
				S_AXI_BRESP <= wr_known ? `ETF_RESP_OKAY : `ETF_RESP_SLVERR;
			if (wr_ctrl)
				en_r <= wd_cur[`ETF_CTRL_EN];
			// flush is a one-cycle pulse, it reads back as zero
			flush_r <= wr_ctrl & wd_cur[`ETF_CTRL_FLUSH];
		end
	end

	// AXI4-Lite read side
	wire [31:0] status_w = {15'h0000, st_r != etf_pkg::FWD_SEL,
		8'h00, full_v};
	wire rd_known = (S_AXI_ARADDR == `ETF_REG_CTRL) |
		(S_AXI_ARADDR == `ETF_REG_STATUS) | (S_AXI_ARADDR == `ETF_REG_DROPS) |
		(S_AXI_ARADDR == `ETF_REG_ERRS) | (S_AXI_ARADDR == `ETF_REG_FWD) |
		(S_AXI_ARADDR == `ETF_REG_HITS) | (S_AXI_ARADDR == `ETF_REG_FMT);
	wire [31:0] rd_mux =
		(S_AXI_ARADDR == `ETF_REG_CTRL)   ? {31'h0000_0000, en_r} :
		(S_AXI_ARADDR == `ETF_REG_STATUS) ? status_w :
		(S_AXI_ARADDR == `ETF_REG_DROPS)  ? drops_r :
		(S_AXI_ARADDR == `ETF_REG_ERRS)   ? errs_r :
		(S_AXI_ARADDR == `ETF_REG_FWD)    ? fwd_r :
		(S_AXI_ARADDR == `ETF_REG_HITS)   ? hits_r :
		(S_AXI_ARADDR == `ETF_REG_FMT)    ? {28'h000_0000, fmt_r} :
		`ETF_ZERO32;
	wire ar_take    = S_AXI_ARVALID & S_AXI_ARREADY;
	wire rvalid_nxt = ar_take | (S_AXI_RVALID & ~S_AXI_RREADY);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= `ETF_ZERO32;
			S_AXI_RRESP   <= `ETF_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= ~rvalid_nxt;
			S_AXI_RVALID  <= rvalid_nxt;
			if (ar_take) begin
				S_AXI_RDATA <= rd_mux;
				S_AXI_RRESP <= rd_known ? `ETF_RESP_OKAY : `ETF_RESP_SLVERR;
			end
		end
	end

	// event counters wrap; several boards may report in one cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			drops_r <= `ETF_ZERO32;
			errs_r  <= `ETF_ZERO32;
			fwd_r   <= `ETF_ZERO32;
		end else begin
			drops_r <= drops_r + 32'($countones(drop_v));
			errs_r  <= errs_r + 32'($countones(bad_v));
			if (sent_last)
				fwd_r <= fwd_r + 32'h0000_0001;
		end
	end

	property p_whole_then_poll;
		@(posedge CLK) disable iff (RST)
		(sent_last && !flush_r) |=> (st_r == etf_pkg::FWD_SEL) && !HOST_VALID;
	endproperty
	a_whole_then_poll: assert property (p_whole_then_poll)
		else $error("poll did not resume after a train");

	property p_found_is_sent;
		@(posedge CLK) disable iff (RST)
		(go && !flush_r) ##1 !flush_r [*2] |=> HOST_VALID;
	endproperty
	a_found_is_sent: assert property (p_found_is_sent)
		else $error("complete train not presented within three cycles");

	property p_first_start;
		@(posedge CLK) disable iff (RST)
		(HOST_VALID && idx_r == '0) |-> HOST_DATA[`ETF_BIT_START];
	endproperty
	a_first_start: assert property (p_first_start)
		else $error("first forwarded word lacks start marker");

	property p_last_end;
		@(posedge CLK) disable iff (RST)
		(HOST_VALID && HOST_LAST) |-> HOST_DATA[`ETF_BIT_END] &&
			!HOST_DATA[`ETF_BIT_START];
	endproperty
	a_last_end: assert property (p_last_end)
		else $error("closing word markers wrong");

	property p_hold_until_taken;
		@(posedge CLK) disable iff (RST)
		(HOST_VALID && !HOST_READY && !flush_r) |=>
			HOST_VALID && $stable(HOST_DATA);
	endproperty
	a_hold_until_taken: assert property (p_hold_until_taken)
		else $error("host word changed before it was taken");

endmodule : etf_framer

// ---- tb/etf_board_model.sv ----
`timescale 1ns/1ps
`include "etf_params.svh"

module etf_board_model (
	input  wire logic                             CLK,
	output etf_pkg::etf_word_t [`ETF_NBOARD-1:0]  BRD_WORD,
	input  wire logic                             HOST_VALID,
	input  wire logic [`ETF_WORD_W-1:0]           HOST_DATA,
	input  wire logic                             HOST_LAST,
	output logic                                  HOST_READY
);
	logic [31:0] bq[`ETF_NBOARD][$];
	logic [32:0] rxq[$];
	logic        slow;
	logic [31:0] idle_pat;

	initial begin
		BRD_WORD = '0;
		HOST_READY = 1'b0;
		slow = 1'b0;
		idle_pat = 32'h0000_0000;
	end

	// a board streams its queued train one word a cycle, back to back
	always @(posedge CLK) begin
		idle_pat <= idle_pat + 32'h9e37_79b9;
		for (int b = 0; b < `ETF_NBOARD; b++) begin
			if (bq[b].size() > 0) begin
				BRD_WORD[b] <= '{valid: 1'b1, data: bq[b].pop_front()};
			end else begin
				// idle lane churns so a stale word can never pass as data
				BRD_WORD[b] <= '{valid: 1'b0, data: idle_pat ^ 32'(b)};
			end
		end
		// slow host stalls every other cycle
		HOST_READY <= slow ? ~HOST_READY : 1'b1;
		if (HOST_VALID && HOST_READY) begin
			rxq.push_back({HOST_LAST, HOST_DATA});
		end
	end

	task push(input int b, input logic [31:0] w);
		bq[b].push_back(w);
	endtask : push
endmodule : etf_board_model

// ---- tb/tb_event_train_framer.sv ----
`timescale 1ns/1ps
`include "etf_params.svh"

module tb_event_train_framer;
	logic                                 clk, rst, hv, hl, hr;
	etf_pkg::etf_word_t [`ETF_NBOARD-1:0] brd;
	logic [31:0]                          hd, wdata, rdata;
	logic [7:0]                           awaddr, araddr;
	logic                                 awvalid, awready, wvalid, wready;
	logic                                 bvalid, bready, arvalid, arready;
	logic                                 rvalid, rready;
	logic [3:0]                           wstrb;
	logic [1:0]                           bresp, rresp;
	logic [31:0]                          tq[$];
	logic [3:0]                           fmts[6];
	int                                   error_cnt, num_checks;
	logic [2:0]                           k;
	logic [7:0]                           seen_m;
	// upper bits carry nonzero routing fields that must pass through
	localparam logic [8:0] HI = 9'h168;

	etf_framer dut (.CLK(clk), .RST(rst), .BRD_WORD(brd), .HOST_VALID(hv),
		.HOST_DATA(hd), .HOST_LAST(hl), .HOST_READY(hr),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	etf_board_model u_prt (.CLK(clk), .BRD_WORD(brd), .HOST_VALID(hv),
		.HOST_DATA(hd), .HOST_LAST(hl), .HOST_READY(hr));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task give_verdict();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// only the watchdog ends a wait for the slave
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge clk);
		end while (!bvalid);
		bready <= 1'b0;
		chk("write resp", 33'(bresp), 33'(`ETF_RESP_OKAY));
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er, input string nm);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
		end while (!arready);
		arvalid <= 1'b0;
		do begin
			@(posedge clk);
		end while (!rvalid);
		rready <= 1'b0;
		chk(nm, 33'(rdata), 33'(ed));
		chk("read resp", 33'(rresp), 33'(er));
	endtask : axi_rd

	task make_train(input logic [3:0] fmt, input int ns, input logic [15:0] h);
		tq.delete();
		tq.push_back({1'b1, HI, fmt, h[15], 2'b10, h[14:0]});
		tq.push_back({1'b1, HI, 4'h0, 3'h0, 15'h0000});
		for (int c = 0; c < 16; c++) begin
			for (int s = 0; s < ns; s++) begin
				tq.push_back({1'b1, HI, 5'(c), 5'h00, 12'(c * 16 + s)});
			end
			if (fmt == 4'h0) begin
				tq.push_back({1'b1, HI, 5'(c), 2'h0, 15'(c + 256)});
			end
		end
		tq.push_back({1'b1, HI, 5'h00, 2'b01, 15'(tq.size() + 1)});
	endtask : make_train

	task send(input int b);
		int n;
		n = 0;
		foreach (tq[i]) u_prt.push(b, tq[i]);
		while (u_prt.bq[b].size() > 0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
	endtask : send

	task expect_train(input int b);
		int          n;
		logic [31:0] e;
		logic [32:0] got;
		n = 0;
		while (u_prt.rxq.size() < tq.size() && n < 5000) begin
			@(posedge clk);
			n++;
		end
		foreach (tq[i]) begin
			e = tq[i];
			e[24:22] = 3'(b);
			got = '0;
			if (u_prt.rxq.size() > 0) begin
				got = u_prt.rxq.pop_front();
			end
			chk("host word", got, {i == tq.size() - 1, e});
		end
	endtask : expect_train

	initial begin
		rst = 1'b1;
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
		fmts = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'he};
		error_cnt = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		axi_rd(`ETF_REG_CTRL, 32'h0000_0001, `ETF_RESP_OKAY, "ctrl");
		axi_rd(`ETF_REG_DROPS, 32'h0000_0000, `ETF_RESP_OKAY, "drops");
		axi_rd(8'h1c, 32'h0000_0000, `ETF_RESP_SLVERR, "unmapped");
		axi_wr(`ETF_REG_STATUS, 32'hffff_ffff);
		axi_rd(`ETF_REG_STATUS, 32'h0000_0000, `ETF_RESP_OKAY, "status ro");
		$display("test registers done");
		make_train(4'h0, 2, 16'h8005);
		send(3);
		expect_train(3);
		axi_rd(`ETF_REG_HITS, 32'h0000_8005, `ETF_RESP_OKAY, "hits");
		$display("test single train done");
		axi_wr(`ETF_REG_CTRL, 32'h0000_0000);
		make_train(4'h1, 1, 16'h0042);
		send(5);
		axi_rd(`ETF_REG_STATUS, 32'h0000_0020, `ETF_RESP_OKAY, "full");
		make_train(4'h1, 3, 16'h0042);
		send(5);
		axi_rd(`ETF_REG_DROPS, 32'h0000_0001, `ETF_RESP_OKAY, "drop");
		u_prt.slow <= 1'b1;
		axi_wr(`ETF_REG_CTRL, 32'h0000_0001);
		make_train(4'h1, 1, 16'h0042);
		expect_train(5);
		$display("test drop done");
		axi_wr(`ETF_REG_CTRL, 32'h0000_0000);
		for (int i = 0; i < 6; i++) begin
			make_train(fmts[i], 1, 16'h8000 | 16'(i));
			send(i);
		end
		axi_rd(`ETF_REG_STATUS, 32'h0000_003f, `ETF_RESP_OKAY, "all");
		axi_wr(`ETF_REG_CTRL, 32'h0000_0001);
		// poll resumes wherever it idled, so each train names its board
		seen_m = 8'h00;
		for (int i = 0; i < 6; i++) begin
			while (u_prt.rxq.size() == 0) @(posedge clk);
			k = u_prt.rxq[0][`ETF_BRD_HI:`ETF_BRD_LO];
			seen_m[k] = 1'b1;
			make_train(fmts[k], 1, 16'h8000 | 16'(k));
			expect_train(k);
		end
		chk("boards seen", 33'(seen_m), 33'h0_0000_003f);
		axi_rd(`ETF_REG_FMT, 32'(fmts[k]), `ETF_RESP_OKAY, "fmt");
		axi_rd(`ETF_REG_HITS, 32'h0000_8000 | 32'(k), `ETF_RESP_OKAY,
			"hits2");
		axi_rd(`ETF_REG_FWD, 32'h0000_0008, `ETF_RESP_OKAY, "fwd");
		$display("test formats done");
		tq.delete();
		tq.push_back(32'h0001_0000);
		send(7);
		axi_rd(`ETF_REG_ERRS, 32'h0000_0001, `ETF_RESP_OKAY, "errs");
		axi_rd(`ETF_REG_STATUS, 32'h0000_0000, `ETF_RESP_OKAY, "rej");
		$display("test invalid word done");
		axi_wr(`ETF_REG_CTRL, 32'h0000_0000);
		make_train(4'h0, 1, 16'h0003);
		send(2);
		axi_rd(`ETF_REG_STATUS, 32'h0000_0004, `ETF_RESP_OKAY, "st2");
		axi_wr(`ETF_REG_CTRL, 32'h0000_0002);
		axi_rd(`ETF_REG_STATUS, 32'h0000_0000, `ETF_RESP_OKAY, "flush");
		axi_rd(`ETF_REG_CTRL, 32'h0000_0000, `ETF_RESP_OKAY, "ctrl0");
		axi_wr(`ETF_REG_CTRL, 32'h0000_0001);
		repeat (50) @(posedge clk);
		chk("leftover", 33'(u_prt.rxq.size()), '0);
		$display("test flush done");
		give_verdict();
	end

	// whole run needs a little over a thousand cycles; this is ample margin
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		$display("ERROR watchdog expired");
		give_verdict();
	end
endmodule : tb_event_train_framer
